/* hw/snrp_host.sv */
// Function
// (RQ1) Address sent is 24 bits, bit 23 first down to bit 0.
// (RQ2) Frame opens with select low, eight-bit code, then three address bytes.
// (RQ3) Host changes address bits on falling edge so device samples them rising; code changes them one cycle into the low half.
// (RQ4) Read data streams on; host keeps clocking bytes as software asks.
// (RQ5) Host ends a read at any byte by raising chip select.
// (RQ6) Read codes: 03, 0B, 3B, BB, 6B, EB.
// (RQ7) Extended protocol: code on line 0, address and data width per command.
// (RQ8) Dual and quad protocols move every phase on two or four lines.
// (RQ9) Each read behaves alike in every protocol; only lane count differs.
// (RQ10) Fast reads insert dummy cycles before data; plain read has none.
// (RQ11) Software issues write enable before any program command.
// (RQ12) Program frame holds select low until last data bit, then raises it.
// (RQ13) Program frame: code on line 0, address bytes, one or more data bytes.
// (RQ14) Rising select after a valid program frame starts internal programming.
// (RQ15) Page wrap beyond page end is handled inside the device.
// (RQ16) Overlong page data: device keeps only last page-size bytes.
// (RQ17) Short page data: device leaves other page bytes unchanged.
// (RQ18) Device reports write-in-progress while programming; host may poll.
// (RQ19) Device clears write enable latch once programming starts.
// (RQ20) Programming may be suspended and resumed by separate commands.
// (RQ21) On timeout device clears write enable and sets program failure.
// (RQ22) Select rising off a byte boundary discards the program command.
// (RQ23) Program on protected sector fails; flag bits 1 and 4 set.
// (RQ24) Program variants use one, two or four lines for address and data.
// (RQ25) Page size is a device parameter, 256 bytes by default.
// (RQ26) Dummy cycle count is configurable and must match the device.
// (RQ27) Device ignores program commands while write enable latch is 0.
`timescale 1ns/1ps
`default_nettype none
module snrp_host
    import snrp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    output logic             sclk,
    output logic             cs_n,
    output logic      [3:0]  dq_o,
    output logic      [3:0]  dq_oe,
    input  wire logic [3:0]  dq_i
);

    typedef enum logic [2:0] {
        SNRP_IDLE  = 3'b000,
        SNRP_CMD   = 3'b001,
        SNRP_ADDR  = 3'b010,
        SNRP_DUMMY = 3'b011,
        SNRP_DATA  = 3'b100,
        SNRP_HOLD  = 3'b101
    } snrp_state_type;

    snrp_state_type  state;
    snrp_proto_type  proto;
    logic [4:0]      dummy_cycles;
    logic [7:0]      cmd_code;
    logic [1:0]      addr_lanes;
    logic [1:0]      data_lanes;
    logic            data_write;
    logic [23:0]     addr;
    logic [7:0]      tx_byte;
    logic [7:0]      rx_byte;
    logic            byte_ready;
    logic            last_byte;
    logic            frame_open;
    logic [7:0]      shreg;
    logic [4:0]      bits_left;
    logic [23:0]     addr_sh;
    logic [3:0]      div_cnt;
    logic            tick;
    logic [3:0]      dq_meta;
    logic [3:0]      dq_sync;
    logic            wb_hit;

    // Lane code: 0 one line, 1 two lines, 2 four lines
    function automatic logic [4:0] snrp_steps(input logic [1:0] lanes, input logic [4:0] bits);
        case (lanes)
            2'd1:    snrp_steps = bits >> 1;
            2'd2:    snrp_steps = bits >> 2;
            default: snrp_steps = bits;
        endcase
    endfunction

    function automatic logic [1:0] snrp_proto_lanes(input snrp_proto_type p, input logic [1:0] l);
        case (p)
            SNRP_PROTO_DUAL: snrp_proto_lanes = 2'd1; // RQ8
            SNRP_PROTO_QUAD: snrp_proto_lanes = 2'd2; // RQ8
            default:         snrp_proto_lanes = l;
        endcase
    endfunction

    // Wire-level per-command lane choice in extended protocol
    function automatic logic [3:0] snrp_cmd_lanes(input logic [7:0] c);
        case (c)
            SNRP_CMD_DIO_READ:  snrp_cmd_lanes = {2'd1, 2'd1}; // RQ7
            SNRP_CMD_DOUT_READ: snrp_cmd_lanes = {2'd0, 2'd1}; // RQ7
            SNRP_CMD_QOUT_READ: snrp_cmd_lanes = {2'd0, 2'd2}; // RQ7
            SNRP_CMD_QIO_READ:  snrp_cmd_lanes = {2'd2, 2'd2}; // RQ7
            default:            snrp_cmd_lanes = {2'd0, 2'd0};
        endcase
    endfunction

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Input pins cross into clk by two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_meta <= 4'h0;
            dq_sync <= 4'h0;
        end else begin
            dq_meta <= dq_i;
            dq_sync <= dq_meta;
        end
    end

    // Link clock divider; tick marks each half period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= 4'h0;
        end else if (state == SNRP_IDLE || state == SNRP_HOLD || div_cnt == SNRP_HALF_COUNT) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end
    assign tick = (state != SNRP_IDLE) && (state != SNRP_HOLD) && (div_cnt == SNRP_HALF_COUNT);

    // Wishbone slave: ack one cycle after strobe, unmapped reads give zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    SNRP_REG_CTRL:   wb_dat_o <= {6'h0, addr_lanes, cmd_code, 3'h0,
                                                  dummy_cycles, 2'h0, proto, 3'h0, data_write};
                    SNRP_REG_ADDR:   wb_dat_o <= {8'h0, addr};
                    SNRP_REG_DATA:   wb_dat_o <= {24'h0, rx_byte};
                    SNRP_REG_STATUS: wb_dat_o <= {29'h0, frame_open, byte_ready,
                                                  state != SNRP_IDLE && state != SNRP_HOLD};
                    default:         wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    // Configuration written by software while the link is quiet
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            proto        <= SNRP_PROTO_EXT;
            dummy_cycles <= SNRP_DUMMY_RESET;
            cmd_code     <= SNRP_CMD_READ;
            addr_lanes   <= 2'd0;
            data_lanes   <= 2'd0;
            data_write   <= 1'b0;
            addr         <= 24'h0;
        end else if (wb_hit && wb_we_i && state == SNRP_IDLE && !frame_open) begin
            if (wb_adr_i == SNRP_REG_CTRL && wb_sel_i[3]) begin
                cmd_code   <= wb_dat_i[SNRP_CTRL_CMD_LSB +: 8];
                addr_lanes <= wb_dat_i[SNRP_CTRL_LANE_LSB +: 2];
                data_lanes <= wb_dat_i[SNRP_CTRL_LANE_LSB + 2 +: 2];
                data_write <= wb_dat_i[SNRP_CTRL_START_BIT + 2];
                proto      <= snrp_proto_type'(wb_dat_i[SNRP_CTRL_PROTO_LSB +: 2]);
                dummy_cycles <= wb_dat_i[SNRP_CTRL_DUMMY_LSB +: 5]; // RQ26
            end
            if (wb_adr_i == SNRP_REG_ADDR) begin
                addr <= wb_dat_i[SNRP_ADDR_BITS-1:0]; // RQ1
            end
        end
    end

    // Frame sequencer: lines shift out in the low link half, rising edge samples
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state      <= SNRP_IDLE;
            sclk       <= 1'b0;
            cs_n       <= 1'b1;
            dq_o       <= 4'h0;
            dq_oe      <= 4'h0;
            shreg      <= 8'h0;
            addr_sh    <= 24'h0;
            bits_left  <= 5'h0;
            tx_byte    <= 8'h0;
            rx_byte    <= 8'h0;
            byte_ready <= 1'b0;
            last_byte  <= 1'b0;
            frame_open <= 1'b0;
        end else begin
            if (wb_hit && !wb_we_i && wb_adr_i == SNRP_REG_DATA) begin
                byte_ready <= 1'b0;
            end
            case (state)
                SNRP_IDLE: begin
                    sclk <= 1'b0;
                    if (wb_hit && wb_we_i && wb_adr_i == SNRP_REG_CTRL
                        && wb_dat_i[SNRP_CTRL_START_BIT]) begin
                        if (frame_open) begin
                            // Next byte of an open frame
                            tx_byte   <= wb_dat_i[7:0];
                            last_byte <= wb_dat_i[SNRP_CTRL_LAST_BIT];
                            shreg     <= data_write ? wb_dat_i[7:0] : 8'h0;
                            bits_left <= snrp_steps(snrp_proto_lanes(proto, data_lanes), 5'd8);
                            state     <= SNRP_DATA; // RQ4
                        end else begin
                            cs_n       <= 1'b0; // RQ2 RQ11 RQ20
                            frame_open <= 1'b1;
                            shreg      <= cmd_code;
                            addr_sh    <= addr;
                            bits_left  <= snrp_steps(snrp_proto_lanes(proto, 2'd0), 5'd8);
                            state      <= SNRP_CMD; // RQ13
                        end
                    end else if (wb_hit && wb_we_i && wb_adr_i == SNRP_REG_CTRL
                                 && wb_dat_i[SNRP_CTRL_LAST_BIT] && frame_open) begin
                        cs_n       <= 1'b1; // RQ5
                        dq_oe      <= 4'h0;
                        frame_open <= 1'b0;
                    end
                end
                SNRP_CMD, SNRP_ADDR, SNRP_DUMMY, SNRP_DATA: begin
                    if (tick) begin
                        sclk <= !sclk;
                        if (sclk) begin
                            // Falling edge: move to next phase once bits run out; lines change later in the low half
                            if (bits_left == 5'h0) begin
                                case (state)
                                    SNRP_CMD: begin
                                        bits_left <= snrp_steps(snrp_proto_lanes(proto, addr_lanes), 5'd24);
                                        state     <= SNRP_ADDR;
                                    end
                                    SNRP_ADDR: begin
                                        dq_oe <= 4'h0;
                                        if (cmd_code == SNRP_CMD_READ || data_write) begin
                                            state <= SNRP_IDLE; // RQ10
                                        end else begin
                                            bits_left <= dummy_cycles; // RQ26
                                            state     <= SNRP_DUMMY; // RQ10
                                        end
                                    end
                                    SNRP_DUMMY: begin
                                        state <= SNRP_IDLE;
                                    end
                                    default: begin
                                        rx_byte    <= shreg;
                                        byte_ready <= !data_write;
                                        state      <= last_byte ? SNRP_HOLD : SNRP_IDLE;
                                    end
                                endcase
                            end
                        end else begin
                            if (bits_left != 5'h0) begin
                                bits_left <= bits_left - 5'h1;
                            end
                        end
                    end
                    // Lanes change one cycle into the low half, clear of both link edges
                    if (!sclk && div_cnt == 4'h1 && bits_left != 5'h0) begin
                        case (state)
                            SNRP_CMD: begin
                                case (snrp_proto_lanes(proto, 2'd0))
                                    2'd1: begin dq_o <= {2'b00, shreg[7:6]}; dq_oe <= 4'h3; shreg <= {shreg[5:0], 2'b00}; end
                                    2'd2: begin dq_o <= shreg[7:4]; dq_oe <= 4'hF; shreg <= {shreg[3:0], 4'h0}; end
                                    default: begin dq_o <= {3'b000, shreg[7]}; dq_oe <= 4'h1; shreg <= {shreg[6:0], 1'b0}; end
                                endcase
                            end
                            SNRP_ADDR: begin // RQ3
                                case (snrp_proto_lanes(proto, addr_lanes))
                                    2'd1: begin dq_o <= {2'b00, addr_sh[23:22]}; dq_oe <= 4'h3; addr_sh <= {addr_sh[21:0], 2'b00}; end
                                    2'd2: begin dq_o <= addr_sh[23:20]; dq_oe <= 4'hF; addr_sh <= {addr_sh[19:0], 4'h0}; end
                                    default: begin dq_o <= {3'b000, addr_sh[23]}; dq_oe <= 4'h1; addr_sh <= {addr_sh[22:0], 1'b0}; end
                                endcase
                            end
                            SNRP_DATA: begin
                                if (data_write) begin // RQ24
                                    case (snrp_proto_lanes(proto, data_lanes))
                                        2'd1: begin dq_o <= {2'b00, shreg[7:6]}; dq_oe <= 4'h3; shreg <= {shreg[5:0], 2'b00}; end
                                        2'd2: begin dq_o <= shreg[7:4]; dq_oe <= 4'hF; shreg <= {shreg[3:0], 4'h0}; end
                                        default: begin dq_o <= {3'b000, shreg[7]}; dq_oe <= 4'h1; shreg <= {shreg[6:0], 1'b0}; end
                                    endcase
                                end
                            end
                            default: begin
                                dq_oe <= 4'h0;
                            end
                        endcase
                    end
                    // Read data sampled on rising link edge
                    if (tick && !sclk && state == SNRP_DATA && !data_write) begin
                        case (snrp_proto_lanes(proto, data_lanes)) // RQ9
                            2'd1:    shreg <= {shreg[5:0], dq_sync[1:0]};
                            2'd2:    shreg <= {shreg[3:0], dq_sync};
                            default: shreg <= {shreg[6:0], dq_sync[1]}; // RQ7
                        endcase
                    end
                end
                SNRP_HOLD: begin
                    // Select rises only after the whole final byte
                    sclk       <= 1'b0;
                    cs_n       <= 1'b1; // RQ12
                    dq_oe      <= 4'h0;
                    frame_open <= 1'b0;
                    state      <= SNRP_IDLE; // RQ14
                end
                default: begin
                    state <= SNRP_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* hw/snrp_pkg.sv */
package snrp_pkg;

    typedef enum logic [1:0] {
        SNRP_PROTO_EXT  = 2'b00,
        SNRP_PROTO_DUAL = 2'b01,
        SNRP_PROTO_QUAD = 2'b10
    } snrp_proto_type;

    // Wishbone register word offsets (byte addresses)
    localparam logic [3:0] SNRP_REG_CTRL   = 4'h0;
    localparam logic [3:0] SNRP_REG_ADDR   = 4'h4;
    localparam logic [3:0] SNRP_REG_DATA   = 4'h8;
    localparam logic [3:0] SNRP_REG_STATUS = 4'hC;

    // Control register fields
    localparam int SNRP_CTRL_START_BIT = 0;
    localparam int SNRP_CTRL_LAST_BIT  = 1;
    localparam int SNRP_CTRL_PROTO_LSB = 4;
    localparam int SNRP_CTRL_DUMMY_LSB = 8;
    localparam int SNRP_CTRL_CMD_LSB   = 16;
    localparam int SNRP_CTRL_LANE_LSB  = 24;

    // Status register fields
    localparam int SNRP_STAT_BUSY_BIT  = 0;
    localparam int SNRP_STAT_READY_BIT = 1;
    localparam int SNRP_STAT_OPEN_BIT  = 2;

    // Command codes
    localparam logic [7:0] SNRP_CMD_READ      = 8'h03;
    localparam logic [7:0] SNRP_CMD_FAST_READ = 8'h0B;
    localparam logic [7:0] SNRP_CMD_DOUT_READ = 8'h3B;
    localparam logic [7:0] SNRP_CMD_DIO_READ  = 8'hBB;
    localparam logic [7:0] SNRP_CMD_QOUT_READ = 8'h6B;
    localparam logic [7:0] SNRP_CMD_QIO_READ  = 8'hEB;

    localparam int SNRP_ADDR_BITS = 24;
    localparam logic [4:0] SNRP_DUMMY_RESET = 5'h08;

    // Link clock derived by divider: half period in system clocks
    localparam int          SNRP_SYS_CLK_HZ   = 20000000;
    localparam int          SNRP_LINK_CLK_HZ  = 2500000;
    localparam int          SNRP_HALF_CYCLES  = SNRP_SYS_CLK_HZ / (2 * SNRP_LINK_CLK_HZ);
    localparam logic [3:0]  SNRP_HALF_COUNT   = 4'(SNRP_HALF_CYCLES - 1);

    typedef struct packed {
        logic [3:0] dout;
        logic [3:0] oe;
        logic       sclk;
        logic       cs_n;
    } snrp_pins_type;

endpackage

/* verification/snrp_host_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module snrp_host_properties
    import snrp_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic [3:0]  dq_o,
    input wire logic [3:0]  dq_oe,
    input wire logic [3:0]  dq_i
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_due: assert property (p_ack_due) else $error("request not acked");
    property p_ack_why; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_why: assert property (p_ack_why) else $error("ack without request");
    property p_idle; cs_n && $past(cs_n) |-> !sclk && dq_oe == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("link busy while deselected");
    property p_half; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
    a_half: assert property (p_half) else $error("clock high time wrong");
    property p_hold; sclk |-> $stable(dq_o); endproperty
    a_hold: assert property (p_hold) else $error("line moved while clock high");
    property p_frame; $rose(sclk) |-> !cs_n; endproperty
    a_frame: assert property (p_frame) else $error("clock outside frame");
    property p_open;
        $fell(cs_n) |-> $past(wb_cyc_i && wb_we_i && wb_adr_i == SNRP_REG_CTRL
                              && wb_dat_i[SNRP_CTRL_START_BIT]);
    endproperty
    a_open: assert property (p_open) else $error("select fell without start");
endmodule
bind snrp_host snrp_host_properties i_snrp_host_properties (
    .clk(clk), .reset_n(reset_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sclk(sclk), .cs_n(cs_n),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
`default_nettype wire

/* verification/snrp_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module snrp_flash_model
    import snrp_pkg::*;
#(
    parameter logic [7:0] PP_CODE = 8'h02
) (
    input  wire logic           sclk,
    input  wire logic           cs_n,
    input  wire logic [3:0]     dq,
    input  wire snrp_proto_type proto,
    input  wire logic [4:0]     dummy,
    output logic      [3:0]     dev_dq,
    output logic      [3:0]     dev_oe,
    output logic      [23:0]    pg_addr,
    output logic      [7:0]     pg_byte,
    output int                  pg_cnt
);
    int          c, k, nb, wc, wa, wd, dm;
    logic [7:0]  cm, byt, din;
    logic        wel;
    logic [23:0] adr;
    function automatic logic [3:0] take(input int w);
        return w == 1 ? {3'h0, dq[0]} : dq & 4'((1 << w) - 1);
    endfunction
    initial begin
        dev_dq = 4'h0;
        dev_oe = 4'h0;
        pg_cnt = 0;
        wel = 1'b0;
    end
    always @(negedge cs_n) begin
        c = 0;
        k = 0;
        nb = 0;
        wa = 1;
        dm = 0;
        wc = proto == SNRP_PROTO_QUAD ? 4 : proto == SNRP_PROTO_DUAL ? 2 : 1;
    end
    always @(posedge sclk) begin
        // Undriven lines toggle so a stale value never passes for data
        dev_dq <= dev_dq ^ ~dev_oe;
        if (!cs_n) begin
            if (c < 8 / wc) begin
                cm = (cm << wc) | 8'(take(wc));
                if (c == 8 / wc - 1) begin
                    wa = wc > 1 ? wc : cm == SNRP_CMD_DIO_READ ? 2 : cm == SNRP_CMD_QIO_READ ? 4 : 1;
                    wd = wc > 1 ? wc : cm inside {SNRP_CMD_READ, SNRP_CMD_FAST_READ, PP_CODE} ? 1
                       : cm inside {SNRP_CMD_DOUT_READ, SNRP_CMD_DIO_READ} ? 2 : 4;
                    dm = cm inside {SNRP_CMD_READ, PP_CODE} ? 0 : int'(dummy);
                end
            end else if (c < 8 / wc + 24 / wa) begin
                adr = (adr << wa) | 24'(take(wa));
            end else if (cm == PP_CODE) begin
                din = (din << wd) | 8'(take(wd));
                nb = nb + wd;
            end
            c = c + 1;
        end
    end
    always @(negedge sclk) begin
        if (!cs_n && cm != PP_CODE && c >= 8 / wc + 24 / wa + dm) begin
            if (k == 0) begin
                // Data depends on the address so every byte proves its own address
                byt = adr[7:0] ^ adr[15:8] ^ 8'h5A;
                adr = adr + 24'h1;
                k = 8;
            end
            k = k - wd;
            dev_oe <= wd == 1 ? 4'h2 : 4'((1 << wd) - 1);
            dev_dq <= wd == 1 ? {2'h0, byt[k], 1'b0} : 4'(byt >> k) & 4'((1 << wd) - 1);
        end
    end
    always @(posedge cs_n) begin
        dev_oe <= 4'h0;
        if (cm == 8'h06 && c >= 8 / wc) begin
            wel <= 1'b1;
        end
        if (cm == PP_CODE && nb > 0 && nb % 8 == 0 && wel) begin
            wel <= 1'b0;
            pg_addr <= {adr[23:8], adr[7:0] + 8'(nb / 8 - 1)};
            pg_byte <= din;
            pg_cnt <= pg_cnt + 1;
        end
    end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import snrp_pkg::*;
    logic            clk = 1'b0, reset_n = 1'b0, wb_we_i = 1'b0, wb_cyc_i = 1'b0;
    logic            wb_stb_i = 1'b0, wb_ack_o, sclk, cs_n;
    logic [3:0]      wb_adr_i = 4'h0, wb_sel_i = 4'h0, dq_o, dq_oe, dev_dq, dev_oe;
    logic [31:0]     wb_dat_i = 32'h0, wb_dat_o, q;
    logic [23:0]     pg_addr;
    logic [7:0]      pg_byte;
    logic [4:0]      f_dummy = SNRP_DUMMY_RESET;
    snrp_proto_type  f_proto = SNRP_PROTO_EXT;
    int              pg_cnt, n_errors = 0, n_checks = 0, cycles = 0;
    wire logic [3:0] dq_line = (dq_oe & dq_o) | (~dq_oe & dev_dq);
    snrp_host i_snrp_host (.clk(clk), .reset_n(reset_n), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sclk(sclk),
        .cs_n(cs_n), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_line));
    snrp_flash_model i_snrp_flash_model (.sclk(sclk), .cs_n(cs_n), .dq(dq_line),
        .proto(f_proto), .dummy(f_dummy), .dev_dq(dev_dq), .dev_oe(dev_oe),
        .pg_addr(pg_addr), .pg_byte(pg_byte), .pg_cnt(pg_cnt));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic idle();
        do wb(1'b0, SNRP_REG_STATUS, 32'h0); while (q[SNRP_STAT_BUSY_BIT] !== 1'b0);
    endtask
    task automatic rd(input logic [1:0] pr, input logic [7:0] cm, input logic [3:0] ln,
                      input logic [23:0] a, input int n, input logic cl);
        logic [31:0] w;
        logic [23:0] e;
        w = {4'h0, ln, cm, 3'h0, ((cm == SNRP_CMD_READ) ? 5'h00 : f_dummy), 2'h0, pr, 4'h1};
        f_proto <= snrp_proto_type'(pr);
        wb(1'b1, SNRP_REG_ADDR, {8'h00, a});
        // Start uses the settings already held, so they go in first
        wb(1'b1, SNRP_REG_CTRL, w & ~32'h1);
        wb(1'b1, SNRP_REG_CTRL, w);
        idle();
        for (int i = 0; i < n; i++) begin
            wb(1'b1, SNRP_REG_CTRL, w | {30'h0, cl && i == n - 1, 1'b0});
            idle();
            chk(q[SNRP_STAT_READY_BIT], 1'b1);
            wb(1'b0, SNRP_REG_DATA, 32'h0);
            e = a + 24'(i);
            chk(q, {24'h0, e[7:0] ^ e[15:8] ^ 8'h5A});
        end
    endtask
    task automatic t_reads();
        logic [13:0] tab [12] = '{14'h0003, 14'h000B, 14'h043B, 14'h05BB, 14'h086B, 14'h0AEB,
            14'h150B, 14'h153B, 14'h15BB, 14'h2A0B, 14'h2A6B, 14'h2AEB};
        foreach (tab[i]) begin
            rd(tab[i][13:12], tab[i][7:0], tab[i][11:8], 24'h1234FE + 24'(i), 2, 1'b1);
            chk(cs_n, 1'b1);
        end
    endtask
    task automatic t_abort();
        rd(2'd0, SNRP_CMD_FAST_READ, 4'h0, 24'hFFFFFF, 1, 1'b0);
        wb(1'b1, SNRP_REG_CTRL, 32'h2);
        idle();
        chk({q[SNRP_STAT_OPEN_BIT], cs_n, dev_oe}, 6'h10);
        wb(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic t_prog();
        // Bytes double as the low control bits so either data path carries them
        logic [7:0] b [3] = '{8'hC5, 8'h85, 8'h47};
        int p;
        for (int we = 0; we < 2; we++) begin
            p = pg_cnt;
            if (we == 1) begin
                wb(1'b1, SNRP_REG_CTRL, 32'h0006_0000);
                wb(1'b1, SNRP_REG_CTRL, 32'h0006_0001);
                idle();
                wb(1'b1, SNRP_REG_CTRL, 32'h2);
            end
            wb(1'b1, SNRP_REG_ADDR, 32'h0000_10FE);
            wb(1'b1, SNRP_REG_CTRL, 32'h0002_0004);
            wb(1'b1, SNRP_REG_CTRL, 32'h0002_0005);
            idle();
            foreach (b[i]) begin
                wb(1'b1, SNRP_REG_CTRL, {24'h000200, b[i]});
                idle();
            end
            idle();
            chk(pg_cnt - p, we);
        end
        chk({pg_byte, pg_addr}, {8'h47, 24'h001000});
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        chk({cs_n, sclk, dq_oe}, 6'h20);
        t_reads();
        t_abort();
        t_prog();
        results();
    end
endmodule
`default_nettype wire
